//--- pkg/pcs_pkg.sv
// Shared constants and types for the program counter sequencer.
package pcs_pkg;
	// Program counter and instruction widths.
	localparam int PC_W    = 13;
	localparam int WORD_W  = 16;
	localparam int PCL_W   = 8;
	// Return stack geometry.
	localparam int STK_DEPTH = 8;
	localparam int STK_PTR_W = 3;
	localparam int STK_CNT_W = 4;
	// Number of interrupt sources with fixed vectors.
	localparam int INT_N = 6;
	// Two documented system clock rates in hertz.
	localparam int SLOW_CLK_HZ = 32768;
	localparam int FAST_CLK_HZ = 3580000;
	// System clock periods per instruction cycle.
	localparam int PHASES = 4;
	// Register indices; the byte address is four times the index.
	localparam logic [3:0] IDX_PCL    = 4'h6;
	localparam logic [3:0] IDX_CTRL   = 4'h8;
	localparam logic [3:0] IDX_STATUS = 4'h9;
	// Control register field and status register field positions.
	localparam int CTRL_FAST_BIT  = 0;
	localparam int STAT_DEPTH_LSB = 16;
	localparam int STAT_FULL_BIT  = 20;
	// Reset values.
	localparam logic [PC_W-1:0]   PC_RESET   = 13'h0000;
	localparam logic [WORD_W-1:0] WORD_DUMMY = 16'h0000;
	localparam logic              FAST_RESET = 1'b0;
	// Fixed vectors in priority order.
	localparam logic [PC_W-1:0] VEC_EXT    = 13'h0004;
	localparam logic [PC_W-1:0] VEC_TMR0   = 13'h0008;
	localparam logic [PC_W-1:0] VEC_TMR1   = 13'h000C;
	localparam logic [PC_W-1:0] VEC_PERIPH = 13'h0010;
	localparam logic [PC_W-1:0] VEC_RTC    = 13'h0014;
	localparam logic [PC_W-1:0] VEC_DIALER = 13'h0018;
	// Phase states in Gray order along the cycle.
	typedef enum logic [1:0] {
		PCS_PH_A = 2'h0,
		PCS_PH_B = 2'h1,
		PCS_PH_C = 2'h3,
		PCS_PH_D = 2'h2
	} pcs_phase_t;
endpackage

//--- pkg/pcs_core_if.sv
// Interface joining the sequencer to its phase generator and return stack.
`timescale 1ns/1ps
interface pcs_core_if;
	import pcs_pkg::*;
	logic [PHASES-1:0]    phase_onehot; // One-hot phase clocks.
	logic                 last_phase;   // High in the final phase of a cycle.
	logic                 push;         // Push a return address.
	logic                 pop;          // Pop the top return address.
	logic [PC_W-1:0]      push_data;    // Address to push.
	logic [PC_W-1:0]      top_data;     // Registered top entry.
	logic                 full;         // All levels hold an entry.
	logic [STK_CNT_W-1:0] depth;        // Entries held.
	modport seq (input phase_onehot, last_phase, top_data, full, depth,
		output push, pop, push_data);
	modport phs (output phase_onehot, last_phase);
	modport stk (input push, pop, push_data, output top_data, full, depth);
endinterface

//--- rtl/pcs_phase_gen.sv
// Divides the system clock into four non-overlapping instruction phases.
`timescale 1ns/1ps
module pcs_phase_gen
	import pcs_pkg::*;
(
	// Clock and reset.
	input  wire logic CLK_IN,
	input  wire logic RST_IN,
	// Phase outputs.
	pcs_core_if.phs   ifc
);
	pcs_phase_t       ph_q;     // Current phase.
	pcs_phase_t       ph_d;     // Next phase.
	logic [PHASES-1:0] oh_q;    // Registered one-hot phase.
	logic [PHASES-1:0] oh_d;    // Next one-hot phase.

	// Step through the phases; one instruction cycle is four clocks.
	always_comb begin
		unique case (ph_q)
			PCS_PH_A: ph_d = PCS_PH_B;
			PCS_PH_B: ph_d = PCS_PH_C;
			PCS_PH_C: ph_d = PCS_PH_D;
			PCS_PH_D: ph_d = PCS_PH_A;
		endcase
		unique case (ph_d)
			PCS_PH_A: oh_d = 4'h1;
			PCS_PH_B: oh_d = 4'h2;
			PCS_PH_C: oh_d = 4'h4;
			PCS_PH_D: oh_d = 4'h8;
		endcase
	end

	// Register the phase; reset starts a fresh cycle in phase A.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			ph_q <= PCS_PH_A;
			oh_q <= 4'h1;
		end else begin
			ph_q <= ph_d;
			oh_q <= oh_d;
		end
	end

	assign ifc.phase_onehot = oh_q;
	assign ifc.last_phase   = (ph_q == PCS_PH_D);
endmodule

//--- rtl/pcs_return_stack.sv
// Eight-level circular return address stack with a registered top entry.
`timescale 1ns/1ps
module pcs_return_stack
	import pcs_pkg::*;
(
	// Clock and reset.
	input  wire logic CLK_IN,
	input  wire logic RST_IN,
	// Stack port.
	pcs_core_if.stk   ifc
);
	logic [PC_W-1:0]      mem [STK_DEPTH];  // Entry storage.
	logic [STK_PTR_W-1:0] wp_q;             // Next free slot.
	logic [STK_PTR_W-1:0] wp_d;             // Next value of the slot pointer.
	logic [STK_CNT_W-1:0] cnt_q;            // Entries held, saturating.
	logic [STK_CNT_W-1:0] cnt_d;            // Next entry count.
	logic [PC_W-1:0]      top_q;            // Registered top entry.

	// Pointer arithmetic. A push onto a full stack wraps and overwrites the
	// oldest entry, so only the eight most recent addresses survive.
	always_comb begin
		wp_d  = wp_q;
		cnt_d = cnt_q;
		if (ifc.push) begin
			wp_d = wp_q + 3'h1;
			if (cnt_q != 4'h8) begin
				cnt_d = cnt_q + 4'h1;
			end
		end else if (ifc.pop && (cnt_q != 4'h0)) begin
			wp_d  = wp_q - 3'h1;
			cnt_d = cnt_q - 4'h1;
		end
	end

	// Top entry lags a push by one clock; pops come at least a cycle later.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			wp_q  <= 3'h0;
			cnt_q <= 4'h0;
			top_q <= PC_RESET;
		end else begin
			wp_q  <= wp_d;
			cnt_q <= cnt_d;
			top_q <= mem[wp_q - 3'h1];
		end
	end

	// Storage write; not reset, and the count guards only pops, not the top entry read.
	always_ff @(posedge CLK_IN) begin
		if (ifc.push) begin
			mem[wp_q] <= ifc.push_data;
		end
	end

	assign ifc.top_data = top_q;
	assign ifc.full     = (cnt_q == 4'h8);
	assign ifc.depth    = cnt_q;
endmodule

//--- rtl/pcs_sequencer.sv
// Instruction sequencer: phases, fetch pipeline, program counter, register bus.
`timescale 1ns/1ps
module pcs_sequencer
	import pcs_pkg::*;
(
	// Clock and reset.
	input  wire logic                        CLK_IN,
	input  wire logic                        RST_IN,
	// Classic Wishbone slave.
	input  wire logic                        WB_CYC_IN,
	input  wire logic                        WB_STB_IN,
	input  wire logic                        WB_WE_IN,
	input  wire logic [5:0]                  WB_ADR_IN,
	input  wire logic [3:0]                  WB_SEL_IN,
	input  wire logic [31:0]                 WB_DAT_IN,
	output logic      [31:0]                 WB_DAT_OUT,
	output logic                             WB_ACK_OUT,
	// Program ROM.
	output logic      [pcs_pkg::PC_W-1:0]    ROM_ADDR_OUT,
	output logic                             ROM_RD_OUT,
	input  wire logic [pcs_pkg::WORD_W-1:0]  ROM_DATA_IN,
	// Execution unit.
	output logic      [pcs_pkg::WORD_W-1:0]  EXEC_WORD_OUT,
	output logic                             EXEC_VALID_OUT,
	output logic      [pcs_pkg::PHASES-1:0]  PHASE_OUT,
	input  wire logic                        CTL_JUMP_IN,
	input  wire logic                        CTL_CALL_IN,
	input  wire logic                        CTL_RET_IN,
	input  wire logic                        CTL_SKIP_IN,
	// Interrupt sources.
	input  wire logic [pcs_pkg::INT_N-1:0]   INT_REQ_IN,
	output logic      [pcs_pkg::INT_N-1:0]   INT_ACK_OUT,
	// System clock rate select.
	output logic                             FAST_CLK_SEL_OUT
);
	// Internal connections to the phase generator and the return stack.
	pcs_core_if ifc ();

	logic [PC_W-1:0]   pc_q;        // Address of the word being fetched.
	logic [PC_W-1:0]   pc_d;        // Next fetch address.
	logic [WORD_W-1:0] word_q;      // Word in the execute stage.
	logic [WORD_W-1:0] word_d;      // Next execute word.
	logic              valid_q;     // Execute word is real, not a dummy.
	logic              valid_d;     // Next execute-valid flag.
	logic              pend_q;      // Software low-byte write waits.
	logic              pend_d;      // Next pending flag.
	logic [PCL_W-1:0]  pclv_q;      // Pending low-byte value.
	logic [PCL_W-1:0]  pclv_d;      // Next pending value.
	logic              fast_q;      // Fast system clock selected.
	logic              fast_d;      // Next clock select.
	logic              ack_q;       // Bus acknowledge.
	logic              ack_d;       // Next acknowledge.
	logic [31:0]       rdat_q;      // Bus read data.
	logic [31:0]       rdat_d;      // Next read data.
	logic [INT_N-1:0]  iack_q;      // Interrupt acknowledge pulse.
	logic [INT_N-1:0]  iack_d;      // Next acknowledge pulse.
	logic              bus_new;     // A bus request not yet answered.
	logic [3:0]        idx;         // Register index from the byte address.
	logic [INT_N-1:0]  int_pick;    // Highest priority pending request.

	// Phase clocks for the whole core.
	pcs_phase_gen u_phase (
		.CLK_IN (CLK_IN),
		.RST_IN (RST_IN),
		.ifc    (ifc.phs)
	);

	// Hardware return stack.
	pcs_return_stack u_stack (
		.CLK_IN (CLK_IN),
		.RST_IN (RST_IN),
		.ifc    (ifc.stk)
	);

	// Picks the lowest numbered request, which owns the lowest vector.
	function automatic logic [INT_N-1:0] first_req(input logic [INT_N-1:0] req);
		logic [INT_N-1:0] one;
		one = '0;
		for (int i = INT_N - 1; i >= 0; i--) begin
			if (req[i]) begin
				one = '0;
				one[i] = 1'b1;
			end
		end
		return one;
	endfunction

	// Maps a one-hot request to its fixed service address.
	function automatic logic [PC_W-1:0] vector_of(input logic [INT_N-1:0] one);
		logic [PC_W-1:0] v;
		v = PC_RESET;
		unique case (1'b1)
			one[0]:  v = VEC_EXT;
			one[1]:  v = VEC_TMR0;
			one[2]:  v = VEC_TMR1;
			one[3]:  v = VEC_PERIPH;
			one[4]:  v = VEC_RTC;
			one[5]:  v = VEC_DIALER;
			default: v = PC_RESET;
		endcase
		return v;
	endfunction

	// Read multiplexer; unmapped and reserved bits read as zero.
	function automatic logic [31:0] reg_read(input logic [3:0] i);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (i)
			IDX_PCL:    r[PCL_W-1:0] = pc_q[PCL_W-1:0];
			IDX_CTRL:   r[CTRL_FAST_BIT] = fast_q;
			IDX_STATUS: begin
				r[PC_W-1:0] = pc_q;
				r[STAT_DEPTH_LSB +: STK_CNT_W] = ifc.depth;
				r[STAT_FULL_BIT] = ifc.full;
			end
			default:    r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	assign bus_new  = WB_CYC_IN && WB_STB_IN && !ack_q;
	assign idx      = WB_ADR_IN[5:2];
	assign int_pick = first_req(INT_REQ_IN);

	// Next-state logic. Every decision about the counter is made at the last
	// phase, so the execution unit has the whole cycle to settle its controls.
	always_comb begin
		pc_d           = pc_q;
		word_d         = word_q;
		valid_d        = valid_q;
		pend_d         = pend_q;
		pclv_d         = pclv_q;
		fast_d         = fast_q;
		ack_d          = bus_new;
		rdat_d         = rdat_q;
		iack_d         = '0;
		ifc.push       = 1'b0;
		ifc.pop        = 1'b0;
		ifc.push_data  = pc_q;
		if (ifc.last_phase) begin
			// A dummy replaces the prefetched word unless no transfer occurs.
			valid_d = 1'b0;
			word_d  = WORD_DUMMY;
			if (valid_q && CTL_RET_IN) begin
				// Return restores all bits from the top of the stack.
				pc_d    = ifc.top_data;
				ifc.pop = 1'b1;
			end else if (valid_q && (CTL_JUMP_IN || CTL_CALL_IN)) begin
				// Target is the address field of the executing word.
				pc_d     = word_q[PC_W-1:0];
				ifc.push = CTL_CALL_IN;
			end else if (valid_q && CTL_SKIP_IN) begin
				// Drop the prefetched word and fetch the one after it.
				pc_d = pc_q + 13'h0001;
			end else if (pend_q) begin
				// Short jump keeps the page bits of the counter.
				pc_d   = {pc_q[PC_W-1:PCL_W], pclv_q};
				pend_d = 1'b0;
			end else if (valid_q && (INT_REQ_IN != '0) && !ifc.full) begin
				// A full stack holds the request back until a return frees a
				// level, so an acknowledge never overwrites a return address.
				pc_d     = vector_of(int_pick);
				iack_d   = int_pick;
				ifc.push = 1'b1;
			end else begin
				// Plain flow: the fetched word moves to execute.
				word_d  = ROM_DATA_IN;
				valid_d = 1'b1;
				pc_d    = pc_q + 13'h0001;
			end
		end
		// Bus access; a write taken here wins over the consume above.
		if (bus_new) begin
			if (WB_WE_IN) begin
				if ((idx == IDX_PCL) && WB_SEL_IN[0]) begin
					pend_d = 1'b1;
					pclv_d = WB_DAT_IN[PCL_W-1:0];
				end
				if ((idx == IDX_CTRL) && WB_SEL_IN[0]) begin
					fast_d = WB_DAT_IN[CTRL_FAST_BIT];
				end
			end else begin
				rdat_d = reg_read(idx);
			end
		end
	end

	// State registers; reset starts fetching at address zero.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			pc_q    <= PC_RESET;
			word_q  <= WORD_DUMMY;
			valid_q <= 1'b0;
			pend_q  <= 1'b0;
			pclv_q  <= 8'h00;
			fast_q  <= FAST_RESET;
			ack_q   <= 1'b0;
			rdat_q  <= 32'h0000_0000;
			iack_q  <= '0;
		end else begin
			pc_q    <= pc_d;
			word_q  <= word_d;
			valid_q <= valid_d;
			pend_q  <= pend_d;
			pclv_q  <= pclv_d;
			fast_q  <= fast_d;
			ack_q   <= ack_d;
			rdat_q  <= rdat_d;
			iack_q  <= iack_d;
		end
	end

	// Outputs. The ROM is read at the start of the cycle and its data are
	// sampled at the last phase, which gives it three clocks of access time.
	assign ROM_ADDR_OUT     = pc_q;
	assign ROM_RD_OUT       = ifc.phase_onehot[0];
	assign EXEC_WORD_OUT    = word_q;
	assign EXEC_VALID_OUT   = valid_q;
	assign PHASE_OUT        = ifc.phase_onehot;
	assign INT_ACK_OUT      = iack_q;
	assign FAST_CLK_SEL_OUT = fast_q;
	assign WB_ACK_OUT       = ack_q;
	assign WB_DAT_OUT       = rdat_q;
endmodule

//--- verif/pcs_seq_props.sv
// Port-level assertions for the program counter sequencer.
`timescale 1ns/1ps
module pcs_seq_props
	import pcs_pkg::*;
(
	// Clock, reset and bus handshake.
	input wire logic                       CLK_IN,
	input wire logic                       RST_IN,
	input wire logic                       WB_CYC_IN,
	input wire logic                       WB_STB_IN,
	input wire logic                       WB_ACK_OUT,
	// Fetch, execute and interrupts.
	input wire logic [pcs_pkg::PC_W-1:0]   ROM_ADDR_OUT,
	input wire logic                       ROM_RD_OUT,
	input wire logic [pcs_pkg::WORD_W-1:0] EXEC_WORD_OUT,
	input wire logic                       EXEC_VALID_OUT,
	input wire logic [pcs_pkg::PHASES-1:0] PHASE_OUT,
	input wire logic                       CTL_JUMP_IN,
	input wire logic                       CTL_CALL_IN,
	input wire logic                       CTL_RET_IN,
	input wire logic                       CTL_SKIP_IN,
	input wire logic [pcs_pkg::INT_N-1:0]  INT_REQ_IN,
	input wire logic [pcs_pkg::INT_N-1:0]  INT_ACK_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	logic [3:0]      quiet_q, quiet_d; // Clocks since the last bus cycle.
	logic [PC_W-1:0] tgt;              // Address field of the executing word.
	logic            go;               // Last clock of a real instruction.
	logic [3:0]      ctl;              // Return, call, jump and skip.
	assign tgt = EXEC_WORD_OUT[PC_W-1:0];
	assign go  = PHASE_OUT[3] && EXEC_VALID_OUT;
	assign ctl = {CTL_RET_IN, CTL_CALL_IN, CTL_JUMP_IN, CTL_SKIP_IN};
	// A pending low-byte write may land two cycles late, so the step check waits it out.
	always_comb begin
		quiet_d = quiet_q;
		if (WB_CYC_IN) begin
			quiet_d = 4'h0;
		end else if (quiet_q != 4'hF) begin
			quiet_d = quiet_q + 4'h1;
		end
	end
	// Registers the quiet count.
	always_ff @(posedge CLK_IN) begin
		quiet_q <= RST_IN ? 4'h0 : quiet_d;
	end
	sequence s_ring;
		PHASE_OUT == 4'h2 ##1 PHASE_OUT == 4'h4 ##1 PHASE_OUT == 4'h8 ##1 PHASE_OUT == 4'h1;
	endsequence
	sequence s_dummy;
		!EXEC_VALID_OUT [*4] ##1 EXEC_VALID_OUT;
	endsequence
	a_phase_ring: assert property (PHASE_OUT[0] |=> s_ring)
		else $error("phase ring broken");
	a_fetch_strobe: assert property (ROM_RD_OUT == PHASE_OUT[0])
		else $error("fetch strobe off phase");
	a_cycle_hold: assert property (!PHASE_OUT[0] |-> $stable({ROM_ADDR_OUT, EXEC_WORD_OUT}))
		else $error("fetch or execute changed mid cycle");
	a_step_one: assert property (go && ctl == 4'h0 && INT_REQ_IN == '0 && quiet_q > 4'hB
		|=> EXEC_VALID_OUT && ROM_ADDR_OUT == $past(ROM_ADDR_OUT) + 13'h1)
		else $error("counter did not step by one");
	a_branch_load: assert property (go && (CTL_JUMP_IN || CTL_CALL_IN) && !CTL_RET_IN
		|=> ROM_ADDR_OUT == $past(tgt) ##0 s_dummy)
		else $error("branch load or dummy wrong");
	a_skip_drop: assert property (go && ctl == 4'h1
		|=> !EXEC_VALID_OUT && ROM_ADDR_OUT == $past(ROM_ADDR_OUT) + 13'h1)
		else $error("skip did not discard");
	a_vec_ext: assert property (INT_ACK_OUT[0] |-> ROM_ADDR_OUT == VEC_EXT)
		else $error("external vector wrong");
	a_vec_tmr0: assert property (INT_ACK_OUT[1] |-> ROM_ADDR_OUT == VEC_TMR0)
		else $error("timer 0 vector wrong");
	a_vec_tmr1: assert property (INT_ACK_OUT[2] |-> ROM_ADDR_OUT == VEC_TMR1)
		else $error("timer 1 vector wrong");
	a_reset_zero: assert property ($fell(RST_IN) |-> ROM_ADDR_OUT == PC_RESET)
		else $error("counter not zero after reset");
	a_bus_answer: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT
		|=> WB_ACK_OUT ##1 !WB_ACK_OUT)
		else $error("bus answer late or long");
endmodule

//--- verif/pcs_rom_model.sv
// Program ROM model with a registered word per fetch strobe.
`timescale 1ns/1ps
module pcs_rom_model
	import pcs_pkg::*;
(
	// Clock and fetch port.
	input  wire logic                       CLK_IN,
	input  wire logic [pcs_pkg::PC_W-1:0]   ADDR_IN,
	input  wire logic                       RD_IN,
	output logic      [pcs_pkg::WORD_W-1:0] DATA_OUT
);
	// A fixed pattern stands in for a table; the address field points forward.
	always_ff @(posedge CLK_IN) begin
		if (RD_IN) begin
			DATA_OUT <= {3'h5, ADDR_IN + 13'h0040};
		end
	end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the sequencer and its register bus.
`timescale 1ns/1ps
module testbench;
	import pcs_pkg::*;
	logic              CLK_IN, RST_IN, WB_CYC_IN, WB_STB_IN, WB_WE_IN, WB_ACK_OUT;
	logic              ROM_RD_OUT, EXEC_VALID_OUT, FAST_CLK_SEL_OUT;
	logic [5:0]        WB_ADR_IN;
	logic [3:0]        WB_SEL_IN, ctl;            // Return, call, jump, skip.
	logic [31:0]       WB_DAT_IN, WB_DAT_OUT, rd; // Data of the last read.
	logic [PC_W-1:0]   ROM_ADDR_OUT, a, w;        // Fetch address, branch field.
	logic [WORD_W-1:0] ROM_DATA_IN, EXEC_WORD_OUT;
	logic [PHASES-1:0] PHASE_OUT;
	logic [INT_N-1:0]  INT_REQ_IN, INT_ACK_OUT, seen; // Acks since last clear.
	logic [PC_W-1:0]   ret_q [8];                 // Expected return addresses.
	logic [PC_W-1:0]   vec [INT_N];
	int                fails, check_count;
	assign vec = '{VEC_EXT, VEC_TMR0, VEC_TMR1, VEC_PERIPH, VEC_RTC, VEC_DIALER};
	pcs_sequencer i_dut (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .WB_CYC_IN(WB_CYC_IN),
		.WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
		.WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT),
		.WB_ACK_OUT(WB_ACK_OUT), .ROM_ADDR_OUT(ROM_ADDR_OUT), .ROM_RD_OUT(ROM_RD_OUT),
		.ROM_DATA_IN(ROM_DATA_IN), .EXEC_WORD_OUT(EXEC_WORD_OUT), .PHASE_OUT(PHASE_OUT),
		.EXEC_VALID_OUT(EXEC_VALID_OUT), .CTL_JUMP_IN(ctl[1]), .CTL_CALL_IN(ctl[2]),
		.CTL_RET_IN(ctl[3]), .CTL_SKIP_IN(ctl[0]), .INT_REQ_IN(INT_REQ_IN),
		.INT_ACK_OUT(INT_ACK_OUT), .FAST_CLK_SEL_OUT(FAST_CLK_SEL_OUT));
	pcs_rom_model i_rom (.CLK_IN(CLK_IN), .ADDR_IN(ROM_ADDR_OUT), .RD_IN(ROM_RD_OUT),
		.DATA_OUT(ROM_DATA_IN));
	// Free-running 200 MHz clock.
	initial begin
		CLK_IN = 1'b0;
		forever #2.5 CLK_IN = ~CLK_IN;
	end
	// Collects interrupt acknowledges, since the pulse lasts one clock.
	always @(posedge CLK_IN) seen <= seen | INT_ACK_OUT;
	// Word the ROM model holds at an address.
	function automatic logic [WORD_W-1:0] word(input logic [PC_W-1:0] x);
		return {3'h5, x + 13'h0040};
	endfunction
	// Counts one comparison and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One classic bus cycle; the answer is awaited, the watchdog bounds it.
	task automatic wb(input logic we, input logic [5:0] adr, input logic [31:0] dat);
		@(posedge CLK_IN);
		WB_CYC_IN <= 1'b1;
		WB_STB_IN <= 1'b1;
		WB_WE_IN <= we;
		WB_ADR_IN <= adr;
		WB_DAT_IN <= dat;
		do @(posedge CLK_IN); while (WB_ACK_OUT !== 1'b1);
		rd = WB_DAT_OUT;
		WB_CYC_IN <= 1'b0;
		WB_STB_IN <= 1'b0;
	endtask
	// Returns just after the edge that opens the next instruction cycle.
	task automatic ic;
		do @(posedge CLK_IN); while (PHASE_OUT !== 4'h8);
		#1;
	endtask
	// Runs one instruction with the given controls and requests.
	task automatic op(input logic [3:0] c, input logic [INT_N-1:0] q);
		ic();
		w = EXEC_WORD_OUT[PC_W-1:0];
		a = ROM_ADDR_OUT;
		seen = '0;
		@(posedge CLK_IN);
		ctl <= c;
		INT_REQ_IN <= q;
		ic();
		@(posedge CLK_IN);
		ctl <= 4'h0;
		INT_REQ_IN <= '0;
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Main sequence.
	initial begin
		{RST_IN, WB_CYC_IN, WB_STB_IN, WB_WE_IN, WB_ADR_IN, WB_DAT_IN} = {1'b1, 41'h0};
		WB_SEL_IN = 4'hF;
		ctl = 4'h0;
		INT_REQ_IN = '0;
		fails = 0;
		check_count = 0;
		repeat (16) @(posedge CLK_IN);
		RST_IN <= 1'b0;
		chk({ROM_ADDR_OUT, PHASE_OUT, EXEC_VALID_OUT, FAST_CLK_SEL_OUT}, 19'h4);
		repeat (3) begin
			op(4'h0, '0);
			chk({EXEC_VALID_OUT, EXEC_WORD_OUT, ROM_ADDR_OUT}, {1'b1, word(a), a + 13'h1});
		end
		op(4'h2, '0);
		chk({EXEC_VALID_OUT, ROM_ADDR_OUT}, {1'b0, w});
		ic();
		chk({EXEC_VALID_OUT, EXEC_WORD_OUT}, {1'b1, word(w)});
		op(4'h1, '0);
		chk({EXEC_VALID_OUT, ROM_ADDR_OUT}, {1'b0, a + 13'h1});
		ic();
		chk(EXEC_WORD_OUT, word(a + 13'h1));
		// Fill the stack, see an interrupt held off, then unwind.
		for (int i = 0; i < 8; i++) begin
			op(4'h4, '0);
			ret_q[i] = a;
			chk(ROM_ADDR_OUT, w);
		end
		wb(1'b0, 6'h24, 32'h0);
		chk(rd[20:16], 5'h18);
		op(4'h0, 6'h01);
		chk({EXEC_VALID_OUT, ROM_ADDR_OUT, seen}, {1'b1, a + 13'h1, 6'h00});
		for (int i = 7; i >= 0; i--) begin
			op(4'h8, '0);
			chk(ROM_ADDR_OUT, ret_q[i]);
		end
		// Every vector, each followed by a return.
		for (int k = 0; k < INT_N; k++) begin
			op(4'h0, 6'h01 << k);
			ret_q[0] = a;
			chk({EXEC_VALID_OUT, ROM_ADDR_OUT}, {1'b0, vec[k]});
			ic();
			chk(seen, 6'h01 << k);
			op(4'h8, '0);
			chk(ROM_ADDR_OUT, ret_q[0]);
		end
		// Low byte jump keeps the page, then reads back.
		ic();
		a = ROM_ADDR_OUT;
		wb(1'b1, 6'h18, 32'h0000_00A5);
		ic();
		if (EXEC_VALID_OUT === 1'b1) ic();
		chk({EXEC_VALID_OUT, ROM_ADDR_OUT}, {1'b0, a[12:8], 8'hA5});
		ic();
		a = ROM_ADDR_OUT;
		wb(1'b0, 6'h18, 32'h0);
		chk(rd, {24'h0, a[7:0]});
		wb(1'b1, 6'h20, 32'h1);
		wb(1'b1, 6'h3C, 32'hFFFF_FFFF);
		wb(1'b0, 6'h20, 32'h0);
		chk(rd, 32'h1);
		chk(FAST_CLK_SEL_OUT, 32'h1);
		wb(1'b0, 6'h3C, 32'h0);
		chk(rd, 32'h0);
		results();
	end
	// Watchdog against a hung handshake or phase ring.
	initial begin
		#100000;
		fails++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		results();
	end
endmodule
bind pcs_sequencer pcs_seq_props i_props (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
	.WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT),
	.ROM_ADDR_OUT(ROM_ADDR_OUT), .ROM_RD_OUT(ROM_RD_OUT), .EXEC_WORD_OUT(EXEC_WORD_OUT),
	.EXEC_VALID_OUT(EXEC_VALID_OUT), .PHASE_OUT(PHASE_OUT), .CTL_JUMP_IN(CTL_JUMP_IN),
	.CTL_CALL_IN(CTL_CALL_IN), .CTL_RET_IN(CTL_RET_IN), .CTL_SKIP_IN(CTL_SKIP_IN),
	.INT_REQ_IN(INT_REQ_IN), .INT_ACK_OUT(INT_ACK_OUT));
